//--- design/wst_consts.svh
`ifndef WST_CONSTS_SVH
`define WST_CONSTS_SVH
// ---------------------------------------------------------------
// counter geometry
// ---------------------------------------------------------------
`define WST_CNT_W          31
`define WST_SLICE_W        16
`define WST_RES_STEP       5
`define WST_CNT_RESET_VAL  31'h0000_0004
`define WST_CNT_ZERO       31'h0000_0000
`define WST_CNT_ONE        31'h0000_0001
// ---------------------------------------------------------------
// timeout reset values
// ---------------------------------------------------------------
`define WST_TIMEOUT_HI_RST 8'h87
`define WST_TIMEOUT_LO_RST 8'h6B
// ---------------------------------------------------------------
// power level codes on the level input
// ---------------------------------------------------------------
`define WST_LVL_ACTIVE     3'h0
`define WST_LVL_ZERO       3'h1
`define WST_LVL_ONE        3'h2
`define WST_LVL_TWO        3'h3
`define WST_LVL_THREE      3'h4
// ---------------------------------------------------------------
// clock source select and timing figures
// ---------------------------------------------------------------
`define WST_SRC_XOSC       1'b0
`define WST_SRC_RC         1'b1
`define WST_XOSC_HZ        32768
`define WST_RC_DIV         750
`define WST_SLEEP_MIN_PER  384
`endif

//--- design/wst_pkg.sv
package wst_pkg;
   // power level as seen by the block
   typedef enum logic [2:0]
   {
      WST_ACTIVE = 3'h0,
      WST_PL0    = 3'h1,
      WST_PL1    = 3'h2,
      WST_PL2    = 3'h3,
      WST_PL3    = 3'h4
   } wst_level_t;
   // pending counter reset handling
   typedef enum
   {
      WST_RUN,
      WST_RST_PEND
   } wst_rst_state_t;
endpackage : wst_pkg

//--- design/wst_tick_if.sv
`timescale 1ns/10ps
// one slow clock rising edge, seen in the fast domain
interface wst_tick_if;
   logic rise; // one-cycle pulse per slow rising edge
   modport src (output rise);
   modport dst (input  rise);
endinterface : wst_tick_if

//--- design/wst_edge.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// two-flop synchroniser and rising edge detector
// ---------------------------------------------------------------
module wst_edge
(
   input  wire logic   clk_i,
   input  wire logic   rst_n_i,
   input  wire logic   pin_i,
   wst_tick_if.src     tick
);
   logic meta;      // first sync stage, read by stage two only
   logic sync;      // second sync stage
   logic last;      // previous synced level
   logic next_meta;
   logic next_sync;
   logic next_last;

   // next values of the chain
   always_comb
   begin
      next_meta = pin_i;
      next_sync = meta;
      next_last = sync;
   end

   // register the chain
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end
      else
      begin
         meta <= next_meta;
         sync <= next_sync;
         last <= next_last;
      end
   end

   // rising edge pulse
   assign tick.rise = sync & ~last;
endmodule : wst_edge

//--- design/wst_top.sv
`timescale 1ns/10ps
`include "wst_consts.svh"
// Contract
// - 31-bit counter, 16-bit selected slice exposed
// - count from crystal or rc clock
// - counter stopped in deepest power level
// - wake event in levels 0-2 wakes chip
// - interval is timeout times two^(5*res)
// - low count byte follows selected slice
// - rc calibration only when allowed, else held
// - event sets pending flag, masked cpu flag
// - resolution selects bits 15:0 to 30:15
// - dma trigger pulse on every event
module wst_top
#(
   parameter int CAL_W = 8  // width of rc calibration word
)
(
   input  wire logic             MCLK_I,
   input  wire logic             RST_N_I,
   input  wire logic             XOSC32_CLK_I,
   input  wire logic             RC_CLK_I,
   input  wire logic             CLK_SRC_I,
   input  wire logic [2:0]       LEVEL_I,
   input  wire logic [1:0]       RES_I,
   input  wire logic             CNT_RESET_I,
   input  wire logic [7:0]       TIMEOUT_HI_I,
   input  wire logic             TIMEOUT_HI_WE_I,
   input  wire logic [7:0]       TIMEOUT_LO_I,
   input  wire logic             TIMEOUT_LO_WE_I,
   input  wire logic             IRQ_MASK_I,
   input  wire logic             PENDING_CLR_I,
   input  wire logic             CPU_FLAG_CLR_I,
   input  wire logic             HS_XOSC_ON_I,
   input  wire logic [CAL_W-1:0] RC_CAL_RESULT_I,
   input  wire logic             RC_CAL_VALID_I,
   output logic [7:0]            COUNT_LO_O,
   output logic [7:0]            COUNT_HI_O,
   output logic [15:0]           TIMEOUT_O,
   output logic                  WAKE_PENDING_O,
   output logic                  CPU_WAKE_IRQ_O,
   output logic                  WAKE_DMA_TRIG_O,
   output logic                  WAKE_REQ_O,
   output logic                  RC_CAL_RUN_O,
   output logic [CAL_W-1:0]      RC_CAL_TRIM_O
);
   // ------------------------------------------------------------
   // slow clock edges
   // ------------------------------------------------------------
   wst_tick_if xosc_tick ();  // crystal edge pulses
   wst_tick_if rc_tick ();    // rc edge pulses

   wst_edge u_xosc_edge
   (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .pin_i   (XOSC32_CLK_I),
      .tick    (xosc_tick)
   );

   wst_edge u_rc_edge
   (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .pin_i   (RC_CLK_I),
      .tick    (rc_tick)
   );

   logic                   slow_tick;  // selected slow edge
   logic                   lvl_sleep;  // levels zero to two
   logic                   lvl_deep;   // deepest level
   wst_pkg::wst_level_t    level;      // decoded level

   assign level = wst_pkg::wst_level_t'(LEVEL_I);
   // source mux
   assign slow_tick = (CLK_SRC_I == `WST_SRC_RC) ?
                      rc_tick.rise : xosc_tick.rise;
   assign lvl_sleep = (level == wst_pkg::WST_PL0) ||
                      (level == wst_pkg::WST_PL1) ||
                      (level == wst_pkg::WST_PL2);
   assign lvl_deep  = (level == wst_pkg::WST_PL3);

   // ------------------------------------------------------------
   // counter and compare
   // ------------------------------------------------------------
   logic [`WST_CNT_W-1:0]   cnt;          // the 31-bit counter
   logic [`WST_CNT_W-1:0]   next_cnt;
   logic [15:0]             timeout;      // compare mantissa
   logic [15:0]             next_timeout;
   wst_pkg::wst_rst_state_t rst_state;    // counter reset pending
   wst_pkg::wst_rst_state_t next_rst_state;
   logic [`WST_SLICE_W-1:0] slice;        // selected window
   logic                    match;        // slice equals timeout
   logic                    event_hit;    // event this cycle
   logic [4:0]              slice_lsb;    // window low bit

   // window position is five bits per resolution step
   assign slice_lsb = 5'(RES_I) * 5'(`WST_RES_STEP);
   assign slice = cnt[slice_lsb +: `WST_SLICE_W];
   assign match = (slice == timeout);
   // counter frozen in the deepest level
   assign event_hit = slow_tick && !lvl_deep && match &&
                      (rst_state == wst_pkg::WST_RUN);

   // counter, reset request and timeout next values
   always_comb
   begin
      next_cnt       = cnt;
      next_rst_state = rst_state;
      next_timeout   = timeout;
      // timeout byte writes
      if (TIMEOUT_HI_WE_I)
      begin
         next_timeout[15:8] = TIMEOUT_HI_I;
      end
      if (TIMEOUT_LO_WE_I)
      begin
         next_timeout[7:0] = TIMEOUT_LO_I;
      end
      case (rst_state)
         wst_pkg::WST_RUN:
         begin
            if (CNT_RESET_I)
            begin
               // applied on the next slow edge
               next_rst_state = wst_pkg::WST_RST_PEND;
            end
            else if (slow_tick && !lvl_deep)
            begin
               if (match)
               begin
                  // event tick counts as first of next period,
                  // so the interval is exactly timeout slices
                  next_cnt = `WST_CNT_ONE;
               end
               else
               begin
                  next_cnt = cnt + `WST_CNT_ONE;
               end
            end
         end
         wst_pkg::WST_RST_PEND:
         begin
            if (slow_tick && !lvl_deep)
            begin
               next_cnt       = `WST_CNT_RESET_VAL;
               next_rst_state = wst_pkg::WST_RUN;
            end
         end
         default:
         begin
            next_rst_state = wst_pkg::WST_RUN;
         end
      endcase
   end

   // register counter state
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         cnt       <= `WST_CNT_ZERO;
         rst_state <= wst_pkg::WST_RUN;
         timeout   <= {`WST_TIMEOUT_HI_RST, `WST_TIMEOUT_LO_RST};
      end
      else
      begin
         cnt       <= next_cnt;
         rst_state <= next_rst_state;
         timeout   <= next_timeout;
      end
   end

   // ------------------------------------------------------------
   // flags, triggers and readback
   // ------------------------------------------------------------
   logic [15:0] next_count;    // readback slice
   logic        next_pending;
   logic        next_cpu_irq;
   logic        next_dma;
   logic        next_wake;

   // set wins over clear on every sticky flag
   always_comb
   begin
      next_count   = slice;
      next_pending = event_hit | (WAKE_PENDING_O & ~PENDING_CLR_I);
      next_cpu_irq = (event_hit & IRQ_MASK_I) |
                     (CPU_WAKE_IRQ_O & ~CPU_FLAG_CLR_I);
      next_dma     = event_hit;
      next_wake    = event_hit & lvl_sleep;
   end

   // register flags and readback
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         COUNT_LO_O      <= 8'h00;
         COUNT_HI_O      <= 8'h00;
         WAKE_PENDING_O  <= 1'b0;
         CPU_WAKE_IRQ_O  <= 1'b0;
         WAKE_DMA_TRIG_O <= 1'b0;
         WAKE_REQ_O      <= 1'b0;
      end
      else
      begin
         COUNT_LO_O      <= next_count[7:0];
         COUNT_HI_O      <= next_count[15:8];
         WAKE_PENDING_O  <= next_pending;
         CPU_WAKE_IRQ_O  <= next_cpu_irq;
         WAKE_DMA_TRIG_O <= next_dma;
         WAKE_REQ_O      <= next_wake;
      end
   end

   assign TIMEOUT_O = timeout;

   // ------------------------------------------------------------
   // rc oscillator calibration
   // ------------------------------------------------------------
   logic             cal_allowed;  // calibration window open
   logic             next_cal_run;
   logic [CAL_W-1:0] next_trim;

   assign cal_allowed = HS_XOSC_ON_I &&
                        ((level == wst_pkg::WST_ACTIVE) ||
                         (level == wst_pkg::WST_PL0));

   // take new results only while allowed, else hold
   always_comb
   begin
      next_cal_run = cal_allowed;
      next_trim    = RC_CAL_TRIM_O;
      if (cal_allowed && RC_CAL_VALID_I)
      begin
         next_trim = RC_CAL_RESULT_I;
      end
   end

   // register calibration state
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         RC_CAL_RUN_O  <= 1'b0;
         RC_CAL_TRIM_O <= '0;
      end
      else
      begin
         RC_CAL_RUN_O  <= next_cal_run;
         RC_CAL_TRIM_O <= next_trim;
      end
   end
endmodule : wst_top

//--- design/wst_end.sv
`timescale 1ns/10ps

//--- tb/wst_clk_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// slow clock sources driving the timer pins
// ---------------------------------------------------------------
module wst_clk_model
#(
   parameter realtime XO_HALF = 160.0, // crystal half period, ns
   parameter realtime RC_HALF = 240.0  // rc half period, ns
)
(
   output logic xo_o, // crystal clock pin
   output logic rc_o  // rc clock pin
);
   // both oscillators run free, as on the board
   initial xo_o = 1'h0;
   initial rc_o = 1'h0;
   always #(XO_HALF) xo_o = ~xo_o;
   always #(RC_HALF) rc_o = ~rc_o;
endmodule : wst_clk_model

//--- tb/wst_top_props.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// port checks of the wake timer
// ---------------------------------------------------------------
module wst_top_props
#(
   parameter int CAL_W = 8 // trim width
)
(
   input wire logic             MCLK_I,
   input wire logic             RST_N_I,
   input wire logic [2:0]       LEVEL_I,
   input wire logic             IRQ_MASK_I,
   input wire logic             PENDING_CLR_I,
   input wire logic             HS_XOSC_ON_I,
   input wire logic             RC_CAL_VALID_I,
   input wire logic [7:0]       TIMEOUT_LO_I,
   input wire logic             TIMEOUT_LO_WE_I,
   input wire logic [15:0]      TIMEOUT_O,
   input wire logic             WAKE_PENDING_O,
   input wire logic             CPU_WAKE_IRQ_O,
   input wire logic             WAKE_DMA_TRIG_O,
   input wire logic             WAKE_REQ_O,
   input wire logic [CAL_W-1:0] RC_CAL_TRIM_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   a_dma_one_cycle :
      assert property (WAKE_DMA_TRIG_O |=> !WAKE_DMA_TRIG_O)
      else $error("dma trigger too long");
   a_wake_in_sleep :
      assert property (WAKE_REQ_O |-> WAKE_DMA_TRIG_O
                       && $past(LEVEL_I) inside {[3'h1:3'h3]})
      else $error("wake request out of place");
   a_event_sets_pend :
      assert property (WAKE_DMA_TRIG_O |-> WAKE_PENDING_O)
      else $error("pending not set");
   a_irq_when_mask :
      assert property (WAKE_DMA_TRIG_O && $past(IRQ_MASK_I)
                       |-> CPU_WAKE_IRQ_O)
      else $error("cpu flag not set");
   a_irq_needs_mask :
      assert property ($rose(CPU_WAKE_IRQ_O)
                       |-> WAKE_DMA_TRIG_O && $past(IRQ_MASK_I))
      else $error("cpu flag set without cause");
   a_no_deep_event :
      assert property (WAKE_DMA_TRIG_O |-> $past(LEVEL_I) != 3'h4)
      else $error("event in deepest level");
   a_pend_sticky :
      assert property (WAKE_PENDING_O && !PENDING_CLR_I
                       |=> WAKE_PENDING_O)
      else $error("pending lost");
   a_timeout_lo_write :
      assert property (TIMEOUT_LO_WE_I
                       |=> TIMEOUT_O[7:0] == $past(TIMEOUT_LO_I))
      else $error("timeout byte not taken");
   a_trim_held :
      assert property ($changed(RC_CAL_TRIM_O) |-> $past(RC_CAL_VALID_I)
                       && $past(HS_XOSC_ON_I) && $past(LEVEL_I) <= 3'h1)
      else $error("trim changed while held");
endmodule : wst_top_props
bind wst_top wst_top_props #(.CAL_W(CAL_W)) i_props
(
   .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .LEVEL_I(LEVEL_I),
   .IRQ_MASK_I(IRQ_MASK_I), .PENDING_CLR_I(PENDING_CLR_I),
   .HS_XOSC_ON_I(HS_XOSC_ON_I), .RC_CAL_VALID_I(RC_CAL_VALID_I),
   .TIMEOUT_LO_I(TIMEOUT_LO_I), .TIMEOUT_LO_WE_I(TIMEOUT_LO_WE_I),
   .TIMEOUT_O(TIMEOUT_O), .WAKE_PENDING_O(WAKE_PENDING_O),
   .CPU_WAKE_IRQ_O(CPU_WAKE_IRQ_O), .WAKE_DMA_TRIG_O(WAKE_DMA_TRIG_O),
   .WAKE_REQ_O(WAKE_REQ_O), .RC_CAL_TRIM_O(RC_CAL_TRIM_O)
);

//--- tb/test_wakeup_sleep_timer.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// wake timer bench
// ---------------------------------------------------------------
module test_wakeup_sleep_timer;
   logic        mclk = 1'h0;                      // 25 mhz clock
   logic        rst_n = 1'h0;                     // reset, low active
   logic        xo, rc, pend, cpu, dma, wake, crun; // pins and flags
   logic        src = 1'h0, crst = 1'h0, twe = 1'h0, mask = 1'h0;
   logic        pclr = 1'h0, fclr = 1'h0, hs = 1'h0, cval = 1'h0;
   logic        e;                                // event seen
   logic [2:0]  lvl = 3'h0;                       // power level
   logic [1:0]  res = 2'h0;                       // resolution
   logic [7:0]  thi = 8'h00, tlo = 8'h00, cres = 8'h00;
   logic [7:0]  cnt_lo, cnt_hi, trim;             // readbacks
   logic [15:0] tmo, v;                           // timeout, count
   int          n_errors = 0, total_checks = 0, c; // tallies
   always #20 mclk = ~mclk;
   wst_clk_model i_clk (.xo_o(xo), .rc_o(rc));
   wst_top #(.CAL_W(8)) i_dut
   (
      .MCLK_I(mclk), .RST_N_I(rst_n), .XOSC32_CLK_I(xo), .RC_CLK_I(rc),
      .CLK_SRC_I(src), .LEVEL_I(lvl), .RES_I(res), .CNT_RESET_I(crst),
      .TIMEOUT_HI_I(thi), .TIMEOUT_HI_WE_I(twe), .TIMEOUT_LO_I(tlo),
      .TIMEOUT_LO_WE_I(twe), .IRQ_MASK_I(mask), .PENDING_CLR_I(pclr),
      .CPU_FLAG_CLR_I(fclr), .HS_XOSC_ON_I(hs), .RC_CAL_RESULT_I(cres),
      .RC_CAL_VALID_I(cval), .COUNT_LO_O(cnt_lo), .COUNT_HI_O(cnt_hi),
      .TIMEOUT_O(tmo), .WAKE_PENDING_O(pend), .CPU_WAKE_IRQ_O(cpu),
      .WAKE_DMA_TRIG_O(dma), .WAKE_REQ_O(wake), .RC_CAL_RUN_O(crun),
      .RC_CAL_TRIM_O(trim)
   );
   // verdict and end of run
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   // hang or stuck signal: count and stop
   task automatic fail(input string m);
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
      end_sim();
   endtask : fail
   // compare one value
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : check
   // wait for the next event, cycles since call
   task automatic wait_evt(output int n);
      n = 0;
      do
      begin
         @(posedge mclk);
         #1;
         n++;
         if (n > 9000)
            fail("no wake event");
      end while (dma !== 1'h1);
   endtask : wait_evt
   // wait for a slow edge through the count byte
   task automatic align;
      logic [7:0] t;
      t = cnt_lo;
      for (int i = 0; i < 100 && cnt_lo === t; i++)
         @(negedge mclk);
      if (cnt_lo === t)
         fail("count byte stuck");
   endtask : align
   // write both timeout bytes
   task automatic wr_to(input logic [15:0] val);
      @(negedge mclk);
      {thi, tlo, twe} = {val, 1'h1};
      @(negedge mclk);
      twe = 1'h0;
   endtask : wr_to
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (15) @(negedge mclk);
      check(tmo, 16'h876B);
      check({cnt_hi, cnt_lo}, 16'h0000);
      @(negedge mclk);
      // short timeouts ahead, so stay out of level two
      {rst_n, lvl, mask} = {1'h1, 3'h2, 1'h1};
      @(negedge mclk);
      crst = 1'h1;
      @(negedge mclk);
      crst = 1'h0;
      align();
      check({8'h00, cnt_lo}, 16'h0004);
      align();
      wr_to(16'h0005);
      wait_evt(c);
      check({12'h000, pend, cpu, dma, wake}, 16'h000F);
      wait_evt(c);
      check(16'(c), 16'h0028);
      @(negedge mclk);
      {pclr, fclr, mask} = 3'h6;
      @(negedge mclk);
      {pclr, fclr} = 2'h0;
      check({14'h0000, pend, cpu}, 16'h0000);
      wait_evt(c);
      check({14'h0000, pend, cpu}, 16'h0002);
      for (int r = 1; r < 3; r++)
      begin
         @(negedge mclk);
         res = 2'(r);
         wr_to(16'h0001);
         wait_evt(c);
         wait_evt(c);
         check(16'(c), 16'((1 << (5 * r)) * 8));
      end
      wr_to(16'h0003);
      @(negedge mclk);
      {src, res} = 3'h4;
      wait_evt(c);
      wait_evt(c);
      check(16'(c), 16'h0024);
      @(negedge mclk);
      lvl = 3'h0;
      wait_evt(c);
      check({15'h0000, wake}, 16'h0000);
      @(negedge mclk);
      lvl = 3'h4;
      repeat (20) @(negedge mclk);
      {v, e} = {cnt_hi, cnt_lo, 1'h0};
      repeat (200) @(negedge mclk) e = e | dma;
      check({cnt_hi, cnt_lo}, v);
      check({15'h0000, e}, 16'h0000);
      {lvl, hs, cres, cval} = {3'h0, 1'h1, 8'hA5, 1'h1};
      @(negedge mclk);
      cval = 1'h0;
      @(negedge mclk);
      check({7'h00, crun, trim}, 16'h01A5);
      {lvl, cres, cval} = {3'h2, 8'h3C, 1'h1};
      repeat (2) @(negedge mclk);
      check({7'h00, crun, trim}, 16'h00A5);
      end_sim();
   end
endmodule : test_wakeup_sleep_timer
